// ==== verilog/cdd_decoder.sv ====
// instruction decoder and address counter of a character display controller
//------------------------------------------------------------
// Notes on behaviour
// R1: two host registers: reg_select low instruction, high data.
// R2: while busy, only the busy-and-address read is honoured.
// R3: busy is 1 during execution, 0 once accepting again.
// R4: host polls busy or spaces instructions beyond execution time.
// R5: clear fills display ram with blanks, address counter to 0.
// R6: return home zeroes counter and display shift, ram untouched.
// R7: host keeps lowest data bit 0 for return home.
// R8: entry mode latches increment/decrement and shift-on-entry.
// R9: shift-on-entry shifts the display with each data access.
// R10: display control latches display, cursor and blink enables.
// R11: shift instruction moves cursor or shifts display, ram untouched.
// R12: mode instruction latches graphic/character select.
// R13: mode instruction latches dc-dc converter power.
// R14: function set latches width, lines, font height, font table.
// R15: glyph address set loads counter, targets glyph ram.
// R16: display address set loads counter, targets display ram.
// R17: status read gives busy on DB7, counter on DB6..DB0.
// R18: data write stores byte at counter in selected ram.
// R19: data read returns byte at counter from selected ram.
// R20: every ram access steps counter by one per direction.
// R21: updated counter is shown only after busy drops.
// R22: four-bit width uses upper lines, two nibbles a byte.
// R23: font table codes 00..10; 11 unused; reset 00.
// R24: clear also forces increment, shift-on-entry unchanged.
// R25: upper nibble first, lower second; busy after whole byte.
// R26: instruction write sets busy, decodes highest set bit, executes.
//------------------------------------------------------------
`default_nettype none
`include "cdd_consts.svh"
module cdd_decoder
  import cdd_pkg::*;
#(
  parameter int CLEAR_CYC = `CLEAR_CYC
) (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  // host bus pins
  input  wire logic       reg_select_i,
  input  wire logic       read_write_sel_i,
  input  wire logic       bus_strobe_i,
  input  wire logic       chip_select_n_i,
  input  wire logic [7:0] db_i,
  output logic      [7:0] db_o,
  output logic            db_oe_b_o,
  // status
  output logic            busy_indicator_o,
  output logic      [6:0] addr_counter_o,
  output logic      [5:0] disp_shift_o,
  // configuration
  output logic            display_on_o,
  output logic            cursor_on_o,
  output logic            blink_on_o,
  output logic            incr_decr_o,
  output logic            shift_on_entry_o,
  output logic            graphic_char_sel_o,
  output logic            dcdc_power_o,
  output logic            bus_width_sel_o,
  output logic            line_count_sel_o,
  output logic            font_height_sel_o,
  output logic      [1:0] font_table_sel_o
);
  localparam int EXEC_CYC = `EXEC_CYC;

  //------------------------------------------------------------
  // pin synchronisers
  //------------------------------------------------------------
  logic [11:0] pin_s1_reg;
  logic [11:0] pin_s2_reg;
  logic        strb_d_reg;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      pin_s1_reg <= 12'h800;
      pin_s2_reg <= 12'h800;
      strb_d_reg <= 1'h0;
    end else begin
      pin_s1_reg <= {chip_select_n_i, bus_strobe_i, reg_select_i, read_write_sel_i, db_i};
      pin_s2_reg <= pin_s1_reg;
      strb_d_reg <= pin_s2_reg[10];
    end
  end

  logic       sel_s;
  logic       strb_s;
  logic       rs_s;
  logic       rw_s;
  logic [7:0] db_s;
  logic       stb_rise;

  assign sel_s    = ~pin_s2_reg[11];
  assign strb_s   = pin_s2_reg[10];
  assign rs_s     = pin_s2_reg[9];
  assign rw_s     = pin_s2_reg[8];
  assign db_s     = pin_s2_reg[7:0];
  assign stb_rise = sel_s & strb_s & ~strb_d_reg;

  //------------------------------------------------------------
  // registers
  //------------------------------------------------------------
  cdd_state_e state_reg;
  cdd_state_e state_next;
  logic [`CNT_W-1:0] cnt_reg;
  logic [`CNT_W-1:0] cnt_next;
  logic        busy_reg;
  logic [6:0]  ac_reg;
  logic [6:0]  ac_vis_reg;
  logic        glyph_sel_reg;
  logic [5:0]  shift_reg;
  logic        nib_reg;
  logic [3:0]  hi_nib_reg;
  logic [7:0]  rd_hold_reg;
  logic [7:0]  db_out_reg;
  logic        oe_b_reg;
  logic [7:0]  fill_cnt_reg;
  logic [`BUF_W-1:0] push_word_reg;
  logic        disp_on_reg;
  logic        cur_on_reg;
  logic        blink_reg;
  logic        incr_reg;
  logic        shent_reg;
  logic        gfx_reg;
  logic        dcdc_reg;
  logic        bw_reg;
  logic        lines_reg;
  logic        fh_reg;
  logic [1:0]  ft_reg;

  //------------------------------------------------------------
  // byte assembly and decode
  //------------------------------------------------------------
  logic       byte_done;
  logic [7:0] wb;
  logic       cmd_go;
  logic       dat_go;

  // R22: four-bit mode carries a byte as two upper-line nibbles
  // R25: byte is complete only on the second nibble
  assign byte_done = stb_rise & (bw_reg | nib_reg);
  assign wb        = bw_reg ? db_s : {hi_nib_reg, db_s[7:4]};
  // R1: reg_select picks instruction or data register
  // R2: busy blocks all but the status read
  assign cmd_go    = byte_done & ~rs_s & ~rw_s & ~busy_reg;
  assign dat_go    = byte_done & rs_s & ~busy_reg;

  logic is_dda;
  logic is_cga;
  logic is_fn;
  logic is_sh;
  logic is_dc;
  logic is_em;
  logic is_home;
  logic is_clr;

  // R26: opcode given by highest set data bit
  assign is_dda  = wb[7];
  assign is_cga  = (wb[7:6] == 2'h1);
  assign is_fn   = (wb[7:5] == 3'h1);
  assign is_sh   = (wb[7:4] == 4'h1);
  assign is_dc   = (wb[7:3] == 5'h01);
  assign is_em   = (wb[7:2] == 6'h01);
  assign is_home = (wb[7:1] == 7'h01);
  assign is_clr  = (wb == 8'h01);

  logic [6:0] ac_step;
  logic [6:0] ac_move;
  logic [5:0] sh_left;
  logic [5:0] sh_right;

  // glyph addresses wrap within six bits
  assign ac_move  = incr_reg ? ac_reg + 7'h01 : ac_reg - 7'h01;
  assign ac_step  = glyph_sel_reg ? {1'h0, ac_move[5:0]} : ac_move;
  assign sh_left  = (shift_reg == 6'h00) ? `LINE_LEN - 6'h01 : shift_reg - 6'h01;
  assign sh_right = (shift_reg == `LINE_LEN - 6'h01) ? 6'h00 : shift_reg + 6'h01;

  //------------------------------------------------------------
  // ram and write buffer
  //------------------------------------------------------------
  logic              buf_in_ready;
  logic              buf_out_valid;
  logic              buf_out_ready;
  logic [`BUF_W-1:0] buf_out_data;
  logic              fill_act;
  logic              dd_we;
  logic [6:0]        dd_waddr;
  logic [7:0]        dd_wdata;
  logic              cg_we;
  logic [7:0]        dd_rdata;
  logic [7:0]        cg_rdata;

  // clearing owns the display ram port, so drained writes wait
  assign buf_out_ready = (state_reg != ST_CLEAR);
  assign fill_act      = (state_reg == ST_CLEAR) & ~fill_cnt_reg[7];
  assign dd_we    = fill_act | (buf_out_valid & buf_out_ready & ~buf_out_data[15]);
  assign dd_waddr = fill_act ? fill_cnt_reg[6:0] : buf_out_data[14:8];
  assign dd_wdata = fill_act ? `BLANK_CODE : buf_out_data[7:0];
  assign cg_we    = buf_out_valid & buf_out_ready & buf_out_data[15];

  cdd_buf2 #(.W(`BUF_W)) u_wbuf (
    .sys_clk_i   (sys_clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (state_reg == ST_PUSH),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (push_word_reg),
    .out_valid_o (buf_out_valid),
    .out_ready_i (buf_out_ready),
    .out_data_o  (buf_out_data)
  );

  cdd_ram #(.AW(`DD_AW)) u_dd_ram (
    .sys_clk_i (sys_clk_i),
    .we_i      (dd_we),
    .waddr_i   (dd_waddr),
    .wdata_i   (dd_wdata),
    .raddr_i   (ac_reg),
    .rdata_o   (dd_rdata)
  );

  cdd_ram #(.AW(`CG_AW)) u_cg_ram (
    .sys_clk_i (sys_clk_i),
    .we_i      (cg_we),
    .waddr_i   (buf_out_data[13:8]),
    .wdata_i   (buf_out_data[7:0]),
    .raddr_i   (ac_reg[5:0]),
    .rdata_o   (cg_rdata)
  );

  //------------------------------------------------------------
  // execution sequencer
  //------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cmd_go && is_clr) begin
          state_next = ST_CLEAR;
          cnt_next   = `CNT_W'(CLEAR_CYC - 1);
        end else if (cmd_go || (dat_go && rw_s)) begin
          state_next = ST_WAIT;
          cnt_next   = `CNT_W'(EXEC_CYC - 1);
        end else if (dat_go) begin
          state_next = ST_PUSH;
        end
      end
      ST_PUSH: begin
        if (buf_in_ready) begin
          state_next = ST_WAIT;
          cnt_next   = `CNT_W'(EXEC_CYC - 1);
        end
      end
      ST_CLEAR: begin
        if (cnt_reg != '0) begin
          cnt_next = cnt_reg - `CNT_W'(1);
        end else if (fill_cnt_reg[7]) begin
          state_next = ST_IDLE;
        end
      end
      ST_WAIT: begin
        if (cnt_reg == '0) begin
          state_next = ST_IDLE;
        end else begin
          cnt_next = cnt_reg - `CNT_W'(1);
        end
      end
      default: begin
        state_next = ST_IDLE;
        cnt_next   = '0;
      end
    endcase
  end

  // R3: busy follows execution, drops as the block goes idle
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
      busy_reg  <= 1'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      busy_reg  <= (state_next != ST_IDLE);
    end
  end

  // R5: blank fill of the display ram during clear
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      fill_cnt_reg <= 8'h80;
    end else if (cmd_go && is_clr) begin
      fill_cnt_reg <= 8'h00;
    end else if (fill_act) begin
      fill_cnt_reg <= fill_cnt_reg + 8'h01;
    end
  end

  // R18: write goes to the ram last chosen, at the old counter
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      push_word_reg <= '0;
    end else if (dat_go && !rw_s) begin
      push_word_reg <= {glyph_sel_reg, ac_reg, wb};
    end
  end

  //------------------------------------------------------------
  // address counter and display shift
  //------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      ac_reg        <= 7'h00;
      glyph_sel_reg <= 1'h0;
    end else if (cmd_go) begin
      // R5: clear and home both restart at display address 0
      // R6: home only repositions
      if (is_clr || is_home) begin
        ac_reg        <= 7'h00;
        glyph_sel_reg <= 1'h0;
      // R16: display address set
      end else if (is_dda) begin
        ac_reg        <= wb[6:0];
        glyph_sel_reg <= 1'h0;
      // R15: glyph address set
      end else if (is_cga) begin
        ac_reg        <= {1'h0, wb[5:0]};
        glyph_sel_reg <= 1'h1;
      // R11: cursor move steps the counter
      end else if (is_sh && wb[1:0] == `SH_MOVE && !wb[3]) begin
        ac_reg <= wb[2] ? ac_reg + 7'h01 : ac_reg - 7'h01;
      end
    // R20: step after every ram read or write
    end else if (dat_go) begin
      ac_reg <= ac_step;
    end
  end

  // R21: counter shown to status reads only once busy is down
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      ac_vis_reg <= 7'h00;
    end else if (!busy_reg) begin
      ac_vis_reg <= ac_reg;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      shift_reg <= 6'h00;
    end else if (cmd_go && (is_clr || is_home)) begin
      shift_reg <= 6'h00;
    // R11: display shift keeps ram and counter
    end else if (cmd_go && is_sh && wb[1:0] == `SH_MOVE && wb[3]) begin
      shift_reg <= wb[2] ? sh_right : sh_left;
    // R9: shift rides along with each data access
    end else if (dat_go && shent_reg) begin
      shift_reg <= incr_reg ? sh_left : sh_right;
    end
  end

  //------------------------------------------------------------
  // mode latches
  //------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      disp_on_reg <= 1'h0;
      cur_on_reg  <= 1'h0;
      blink_reg   <= 1'h0;
      incr_reg    <= `INCR_RST;
      shent_reg   <= 1'h0;
      gfx_reg     <= 1'h0;
      dcdc_reg    <= 1'h0;
      bw_reg      <= `BW_RST;
      lines_reg   <= 1'h0;
      fh_reg      <= 1'h0;
      ft_reg      <= `FT_RST;
    end else if (cmd_go) begin
      // R24: clear forces increment only
      if (is_clr) begin
        incr_reg <= 1'h1;
      end
      // R8: entry mode bits
      if (is_em) begin
        incr_reg  <= wb[1];
        shent_reg <= wb[0];
      end
      // R10: display enables
      if (is_dc) begin
        disp_on_reg <= wb[2];
        cur_on_reg  <= wb[1];
        blink_reg   <= wb[0];
      end
      // R12: graphic select
      // R13: converter power
      if (is_sh && wb[1:0] == `SH_MODE) begin
        gfx_reg  <= wb[3];
        dcdc_reg <= wb[2];
      end
      // R14: function set fields
      if (is_fn) begin
        bw_reg    <= wb[4];
        lines_reg <= wb[3];
        fh_reg    <= wb[2];
        // R23: unused font table code leaves the table alone
        if (wb[1:0] != `FT_UNUSED) begin
          ft_reg <= wb[1:0];
        end
      end
    end
  end

  //------------------------------------------------------------
  // pin side: nibble phase and read data
  //------------------------------------------------------------
  // R25: upper nibble first; phase resets in eight-bit mode
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i || bw_reg) begin
      nib_reg    <= 1'h0;
      hi_nib_reg <= 4'h0;
    end else if (stb_rise) begin
      nib_reg    <= ~nib_reg;
      hi_nib_reg <= nib_reg ? hi_nib_reg : db_s[7:4];
    end
  end

  // R17: status word is busy plus visible counter
  // R19: data read returns the selected ram at the counter
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      rd_hold_reg <= 8'h00;
      db_out_reg  <= 8'h00;
    end else if (stb_rise && rw_s) begin
      if (!nib_reg) begin
        rd_hold_reg <= rs_s ? (glyph_sel_reg ? cg_rdata : dd_rdata) : {busy_reg, ac_vis_reg};
        db_out_reg  <= rs_s ? (glyph_sel_reg ? cg_rdata : dd_rdata) : {busy_reg, ac_vis_reg};
        if (!bw_reg) begin
          db_out_reg[3:0] <= 4'h0;
        end
      end else begin
        db_out_reg <= {rd_hold_reg[3:0], 4'h0};
      end
    end
  end

  // pins driven only while a selected read strobe is high
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      oe_b_reg <= 1'h1;
    end else begin
      oe_b_reg <= ~(sel_s & rw_s & strb_s);
    end
  end

  //------------------------------------------------------------
  // outputs
  //------------------------------------------------------------
  assign db_o               = db_out_reg;
  assign db_oe_b_o          = oe_b_reg;
  assign busy_indicator_o   = busy_reg;
  assign addr_counter_o     = ac_reg;
  assign disp_shift_o       = shift_reg;
  assign display_on_o       = disp_on_reg;
  assign cursor_on_o        = cur_on_reg;
  assign blink_on_o         = blink_reg;
  assign incr_decr_o        = incr_reg;
  assign shift_on_entry_o   = shent_reg;
  assign graphic_char_sel_o = gfx_reg;
  assign dcdc_power_o       = dcdc_reg;
  assign bus_width_sel_o    = bw_reg;
  assign line_count_sel_o   = lines_reg;
  assign font_height_sel_o  = fh_reg;
  assign font_table_sel_o   = ft_reg;

  //------------------------------------------------------------
  // assertions
  //------------------------------------------------------------
  a_busy_on_cmd: assert property ( // R26
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    cmd_go |=> busy_reg ##1 busy_reg)
    else $error("busy not raised by instruction");

  a_busy_release: assert property ( // R3
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    state_reg == ST_WAIT && cnt_reg == '0 |=> !busy_reg)
    else $error("busy not released after execution");

  a_clear_home: assert property ( // R24
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    cmd_go && is_clr |=> ac_reg == 7'h00 && incr_reg && shift_reg == 6'h00
      && shent_reg == $past(shent_reg))
    else $error("clear did not reset counter and direction");

  a_busy_ignore: assert property ( // R2
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    byte_done && busy_reg |=> $stable({disp_on_reg, cur_on_reg, blink_reg, incr_reg,
      shent_reg, bw_reg, ft_reg}))
    else $error("instruction taken while busy");

  a_status_word: assert property ( // R17
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    stb_rise && rw_s && !rs_s && bw_reg |=> db_out_reg == {$past(busy_reg), $past(ac_vis_reg)})
    else $error("status read word wrong");

  a_ac_step: assert property ( // R20
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    dat_go && !glyph_sel_reg |=>
      ac_reg == ($past(incr_reg) ? $past(ac_reg) + 7'h01 : $past(ac_reg) - 7'h01))
    else $error("counter not stepped after ram access");

  a_ac_hidden: assert property ( // R21
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    busy_reg |=> ac_vis_reg == $past(ac_vis_reg))
    else $error("counter shown while busy");

  a_ft_reserved: assert property ( // R23
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    cmd_go && is_fn && wb[1:0] == `FT_UNUSED |=> ft_reg == $past(ft_reg))
    else $error("unused font table code taken");

  a_write_lands: assert property ( // R18
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    dat_go && !rw_s |=> state_reg == ST_PUSH && push_word_reg[7:0] == $past(wb))
    else $error("data write not queued");
endmodule
`default_nettype wire

// ==== verilog/cdd_consts.svh ====
// constants of the character display instruction decoder
`ifndef CDD_CONSTS_SVH
`define CDD_CONSTS_SVH
`define SYS_CLK_MHZ   40
`define CLEAR_TIME_US 6200
`define CLEAR_CYC     (`CLEAR_TIME_US * `SYS_CLK_MHZ)
`define EXEC_TIME_NS  100
`define EXEC_CYC      ((`EXEC_TIME_NS * `SYS_CLK_MHZ + 999) / 1000)
`define CNT_W         18
`define DD_AW         7
`define CG_AW         6
`define BUF_W         16
`define BLANK_CODE    8'h20
`define LINE_LEN      6'h28
`define BW_RST        1'h1
`define INCR_RST      1'h1
`define FT_RST        2'h0
`define FT_UNUSED     2'h3
`define SH_MOVE       2'h0
`define SH_MODE       2'h3
`endif

// ==== verilog/cdd_pkg.sv ====
// types of the character display instruction decoder
`default_nettype none
package cdd_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_PUSH  = 4'h2,
    ST_CLEAR = 4'h4,
    ST_WAIT  = 4'h8
  } cdd_state_e;
endpackage
`default_nettype wire

// ==== verilog/cdd_ram.sv ====
// byte-wide ram with registered read data
`default_nettype none
module cdd_ram #(
  parameter int AW = 7
) (
  // clock
  input  wire logic          sys_clk_i,
  // write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [7:0]    wdata_i,
  // read port
  input  wire logic [AW-1:0] raddr_i,
  output logic      [7:0]    rdata_o
);
  logic [7:0] mem_reg [2**AW];
  logic [7:0] rdata_reg;

  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    rdata_reg <= mem_reg[raddr_i];
  end

  assign rdata_o = rdata_reg;
endmodule
`default_nettype wire

// ==== verilog/cdd_buf2.sv ====
// two-entry buffer with valid and ready on both sides
`default_nettype none
module cdd_buf2 #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_b_i,
  // fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);
  logic [1:0]   cnt_reg;
  logic [W-1:0] ent0_reg;
  logic [W-1:0] ent1_reg;
  logic         push;
  logic         pop;

  assign in_ready_o  = (cnt_reg != 2'h2);
  assign out_valid_o = (cnt_reg != 2'h0);
  assign out_data_o  = ent0_reg;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      cnt_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_reg + {1'h0, push} - {1'h0, pop};
    end
  end

  // head shifts forward on pop; a push into an empty buffer lands directly at the head
  always_ff @(posedge sys_clk_i) begin
    if (pop) begin
      ent0_reg <= (cnt_reg == 2'h1) ? in_data_i : ent1_reg;
    end else if (push && cnt_reg == 2'h0) begin
      ent0_reg <= in_data_i;
    end
    if (push && !pop && cnt_reg == 2'h1) begin
      ent1_reg <= in_data_i;
    end
  end

  a_buf_order: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    pop && cnt_reg == 2'h2 |=> out_data_o == $past(ent1_reg))
    else $error("buffer lost word order");
endmodule
`default_nettype wire

// ==== tb/cdd_host.sv ====
// host processor model driving the decoder pins
`default_nettype none
module cdd_host (
  // clock
  input  wire logic       sys_clk_i,
  // bus pins
  output logic            rs_o,
  output logic            rw_o,
  output logic            stb_o,
  output logic            cs_n_o,
  output logic      [7:0] db_o,
  input  wire logic [7:0] db_i
);
  timeunit 1ns;
  timeprecision 1ps;
  bit nib = 1'b0;
  initial begin
    {rs_o, rw_o, stb_o, cs_n_o, db_o} = 12'h100;
  end
  //------------------------------------------
  // one byte, two strobes when narrow
  //------------------------------------------
  // upper nibble first
  task automatic xfer(input logic r, input logic w, input logic [7:0] d,
                      output logic [7:0] q);
    for (int k = 0; k <= int'(nib); k++) begin
      @(posedge sys_clk_i);
      rs_o <= r;
      rw_o <= w;
      cs_n_o <= 1'b0;
      db_o <= w ? ~db_o : (k == 1 ? {d[3:0], ~d[7:4]} : d);
      // setup covers the pin synchronisers
      repeat (4) @(posedge sys_clk_i);
      stb_o <= 1'b1;
      repeat (6) @(posedge sys_clk_i);
      q = nib ? {q[3:0], db_i[7:4]} : db_i;
      stb_o <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      cs_n_o <= 1'b1;
      // released lines must not keep the old value
      db_o <= ~db_o;
      repeat (4) @(posedge sys_clk_i);
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/char_display_instruction_decoder_test.sv ====
// bench for the instruction decoder against a behavioural model
`default_nettype none
module char_display_instruction_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 0;
  logic       rst_b = 0;
  logic       rs, rw, stb, cs_n, oe_b, busy, dsp, cur, blk, inc, soe, gc, pwr, bw, ln, fh;
  logic [7:0] hdb, q8, pin, a, q;
  logic [5:0] sh;
  logic [6:0] acl;
  logic [1:0] ft;
  logic [7:0] dd [128];
  logic [7:0] cg [64];
  int         err_count = 0;
  int         checked = 0;
  int         cyc = 0;
  int         ac = 0;
  bit         s_cg = 0;
  bit         m_inc = 1;
  assign pin = oe_b ? hdb : q8;
  always #12.5 clk = ~clk;
  cdd_decoder #(.CLEAR_CYC(200)) cdd_decoder_i (.sys_clk_i(clk), .rst_b_i(rst_b),
    .reg_select_i(rs), .read_write_sel_i(rw), .bus_strobe_i(stb), .chip_select_n_i(cs_n),
    .db_i(pin), .db_o(q8), .db_oe_b_o(oe_b), .busy_indicator_o(busy), .addr_counter_o(acl),
    .disp_shift_o(sh), .display_on_o(dsp), .cursor_on_o(cur), .blink_on_o(blk),
    .incr_decr_o(inc), .shift_on_entry_o(soe), .graphic_char_sel_o(gc), .dcdc_power_o(pwr),
    .bus_width_sel_o(bw), .line_count_sel_o(ln), .font_height_sel_o(fh), .font_table_sel_o(ft));
  cdd_host cdd_host_i (.sys_clk_i(clk), .rs_o(rs), .rw_o(rw), .stb_o(stb), .cs_n_o(cs_n),
    .db_o(hdb), .db_i(pin));
  //------------------------------------------
  // checking and bus helpers
  //------------------------------------------
  task automatic complete_run();
    $display("checks=%0d errors=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic io(input logic r, input logic w, input logic [7:0] d);
    cdd_host_i.xfer(r, w, d, q);
  endtask
  // poll busy, bounded at 40 reads so a stuck flag is logged as an error
  task automatic idle();
    for (int i = 0; i < 40; i++) begin
      io(1'b0, 1'b1, 8'h00);
      if (q[7] === 1'b0) return;
    end
    chk(q, 8'h00);
  endtask
  task automatic ins(input logic [7:0] b);
    io(1'b0, 1'b0, b);
    idle();
  endtask
  task automatic st();
    io(1'b0, 1'b1, 8'h00);
    chk(q, 8'(ac));
    chk({1'h0, acl}, 8'(ac));
  endtask
  task automatic acc(input logic w, input logic [7:0] d);
    if (w && s_cg) cg[ac] = d;
    if (w && !s_cg) dd[ac] = d;
    io(1'b1, ~w, d);
    if (!w) chk(q, s_cg ? cg[ac] : dd[ac]);
    ac = (ac + (m_inc ? 1 : -1)) & (s_cg ? 63 : 127);
    idle();
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      complete_run();
    end
  end
  //------------------------------------------
  // scenarios
  //------------------------------------------
  initial begin
    void'($urandom(73));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    chk({busy, inc, bw, ft, soe, 2'h0}, 8'h60);
    st();
    ins(8'h04);
    io(1'b0, 1'b0, 8'h01);
    io(1'b0, 1'b0, 8'h0f);
    io(1'b0, 1'b1, 8'h00);
    chk({7'h0, q[7]}, 8'h01);
    idle();
    foreach (dd[i]) dd[i] = 8'h20;
    chk({6'h0, dsp, inc}, 8'h01);
    st();
    acc(1'b0, 8'h00);
    for (int i = 0; i < 8; i++) begin
      ins(8'h08 | 8'(i));
      chk({5'h0, dsp, cur, blk}, 8'(i));
    end
    for (int i = 0; i < 4; i++) begin
      ins(8'h13 | 8'(i << 2));
      chk({6'h0, gc, pwr}, 8'(i));
    end
    ins(8'h3f);
    chk({3'h0, bw, ln, fh, ft}, 8'h1c);
    ins(8'h3e);
    chk({3'h0, bw, ln, fh, ft}, 8'h1e);
    for (int p = 0; p < 3; p++) begin
      ins(p == 1 ? 8'h04 : 8'h06);
      m_inc = p != 1;
      s_cg = p == 2;
      a = p == 2 ? (8'h40 | 8'($urandom % 64)) : (8'h80 | 8'($urandom % 128));
      ins(a);
      ac = a & (s_cg ? 63 : 127);
      st();
      repeat (4) acc(1'b1, 8'($urandom));
      st();
      ins(a);
      ac = a & (s_cg ? 63 : 127);
      repeat (4) acc(1'b0, 8'h00);
    end
    ins(8'h85);
    s_cg = 0;
    ac = 6;
    ins(8'h14);
    st();
    ins(8'h10);
    ac = 5;
    st();
    ins(8'h1c);
    st();
    chk({2'h0, sh}, 8'h01);
    ins(8'h18);
    ins(8'h18);
    chk({2'h0, sh}, 8'h27);
    ins(8'h02);
    ac = 0;
    st();
    chk({2'h0, sh}, 8'h00);
    ins(8'h07);
    acc(1'b1, 8'h41);
    chk({1'h0, soe, sh}, 8'h67);
    ins(8'h06);
    io(1'b0, 1'b0, 8'h2c);
    cdd_host_i.nib = 1'b1;
    idle();
    chk({7'h0, bw}, 8'h00);
    a = 8'h80 | 8'($urandom % 128);
    ins(a);
    ac = a & 127;
    repeat (3) acc(1'b1, 8'($urandom));
    ins(a);
    ac = a & 127;
    repeat (3) acc(1'b0, 8'h00);
    st();
    complete_run();
  end
endmodule
`default_nettype wire
